// [tb_usb_buffer_descriptor_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_usb_buffer_descriptor_ram;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cpu_en = 1'b0;
    logic        cpu_we = 1'b0;
    logic [11:0] cpu_addr = 12'h000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [15:0] ep_in_enable = 16'h0002;
    logic        tok_valid, tok_ready, rx_valid, rx_ready, rx_last, rx_err;
    logic        tx_valid, tx_ready, tx_last, hs_valid, trn_done, stall_set;
    logic [3:0]  tok_pid, tok_data_pid, tok_ep, trn_pid, stall_ep;
    logic [5:0]  tok_bd, trn_bd;
    logic [7:0]  cpu_rdata, rx_data, tx_data, rd;
    logic [1:0]  hs_code, hs_last;
    int          mismatches = 0;
    int          n_checks = 0;
    int          hs_cnt, done_cnt, stall_cnt;

    ubd_ram dut_u (.*);
    ubd_engine_model host_u (.*);

    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (hs_valid)
        begin
            hs_cnt++;
            hs_last = hs_code;
        end
        done_cnt += int'(trn_done);
        stall_cnt += int'(stall_set);
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic timeout_hit();
        chk("wait bound", 8'h00, 8'h01);
        final_report();
    endtask

    task automatic cpu(input logic we, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        cpu_en = 1'b1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge core_clk);
        #1;
        cpu_en = 1'b0;
        rd = cpu_rdata;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] exp);
        cpu(1'b0, a, 8'h00);
        chk(what, exp, rd);
    endtask

    // descriptor 2 sits at 408h, buffer at 480h
    task automatic xfer(input logic [3:0] pid, input bit d1, input int n, input int err,
                        input logic [7:0] st, input logic [7:0] cnt, input logic [7:0] e_hs,
                        input logic [7:0] e_st, input logic [7:0] e_cnt, input logic [7:0] e_dat);
        int k;
        cpu(1'b1, 12'h480, 8'hEE);
        cpu(1'b1, 12'h409, cnt);
        cpu(1'b1, 12'h40A, 8'h80);
        cpu(1'b1, 12'h40B, 8'h04);
        cpu(1'b1, 12'h408, st);
        hs_cnt = 0;
        done_cnt = 0;
        stall_cnt = 0;
        host_u.send(pid, d1 ? ubd_pkg::PID_DATA1 : ubd_pkg::PID_DATA0, 6'h02, 4'h1, n, err);
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (!tok_ready && k < 300);
        if (k >= 300)
            timeout_hit();
        repeat (3) @(posedge core_clk);
        #1;
        chk("handshake", e_hs, (hs_cnt == 0) ? 8'h03 : {6'h00, hs_last});
        chk("done", {7'h00, e_st !== st}, 8'(done_cnt));
        chk("stall", {7'h00, e_hs == 8'h02}, 8'(stall_cnt));
        rdchk("status", 12'h408, e_st);
        rdchk("count", 12'h409, e_cnt);
        rdchk("buffer", 12'h480, e_dat);
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        cpu(1'b1, 12'h400, 8'hC3);
        cpu(1'b1, 12'h4FF, 8'h3C);
        cpu(1'b1, 12'h500, 8'h77);
        rdchk("ram", 12'h400, 8'hC3);
        rdchk("ram", 12'h4FF, 8'h3C);
        rdchk("ram", 12'h500, 8'h00);
        rdchk("ram", 12'h3FF, 8'h00);
        xfer(ubd_pkg::PID_OUT, 0, 3, -1, 8'h88, 8'h04, 8'h00, 8'h04, 8'h03, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 1, 3, -1, 8'h88, 8'h04, 8'h00, 8'h88, 8'h04, 8'hEE);
        xfer(ubd_pkg::PID_OUT, 1, 3, -1, 8'hC8, 8'h04, 8'h00, 8'h04, 8'h03, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 1, 1, -1, 8'h80, 8'h04, 8'h00, 8'h04, 8'h01, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 0, 3, 1, 8'h80, 8'h04, 8'h01, 8'h80, 8'h04, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 0, 5, -1, 8'h80, 8'h04, 8'h01, 8'h80, 8'h04, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 0, 1, -1, 8'h84, 8'h04, 8'h02, 8'h84, 8'h04, 8'hEE);
        xfer(ubd_pkg::PID_SETUP, 0, 2, -1, 8'h84, 8'h04, 8'h00, 8'h34, 8'h02, 8'hA0);
        xfer(ubd_pkg::PID_OUT, 0, 1, -1, 8'h00, 8'h04, 8'h01, 8'h00, 8'h04, 8'hEE);
        xfer(ubd_pkg::PID_OUT, 0, 2, -1, 8'h81, 8'h00, 8'h00, 8'h04, 8'h02, 8'hA0);
        ep_in_enable = 16'h0000;
        xfer(ubd_pkg::PID_OUT, 0, 1, -1, 8'h80, 8'h04, 8'h01, 8'h80, 8'h04, 8'hEE);
        ep_in_enable = 16'h0002;
        cpu(1'b1, 12'h481, 8'h5A);
        xfer(ubd_pkg::PID_IN, 0, 0, -1, 8'h80, 8'h02, 8'h03, 8'h24, 8'h02, 8'hEE);
        chk("tx count", 8'h02, 8'(host_u.tx_seen.size()));
        chk("tx byte", 8'hEE, host_u.tx_seen[0][7:0]);
        chk("tx byte", 8'h5A, host_u.tx_seen[1][7:0]);
        chk("tx last", 8'h01, {6'h00, host_u.tx_seen[0][8], host_u.tx_seen[1][8]});
        final_report();
    end

    initial
    begin
        repeat (50000) @(posedge core_clk);
        timeout_hit();
    end
endmodule
`default_nettype wire

// [ubd_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ubd_engine_model (
    // clock
    input wire logic        core_clk,
    // token channel
    output logic            tok_valid,
    input wire logic        tok_ready,
    output logic [3:0]      tok_pid,
    output logic [3:0]      tok_data_pid,
    output logic [5:0]      tok_bd,
    output logic [3:0]      tok_ep,
    // received bytes
    output logic            rx_valid,
    input wire logic        rx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            rx_err,
    // transmitted bytes
    input wire logic        tx_valid,
    output logic            tx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_last
);
    // each beat taken is kept as {last, data}
    logic [8:0] tx_seen [$];
    int         cyc = 0;

    initial
    begin
        tok_valid = 1'b0;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_err = 1'b0;
        tx_ready = 1'b0;
    end

    // ready only every third cycle so the sender has to hold its byte
    always @(posedge core_clk)
    begin
        if (tx_valid && tx_ready)
            tx_seen.push_back({tx_last, tx_data});
        cyc++;
        #1;
        tx_ready = (cyc % 3 == 0);
    end

    task automatic hold(input bit rx);
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (!(rx ? rx_ready : tok_ready) && k < 500);
        if (k >= 500)
            tb_usb_buffer_descriptor_ram.timeout_hit();
    endtask

    task automatic send(input logic [3:0] pid, input logic [3:0] dpid, input logic [5:0] bd,
                        input logic [3:0] ep, input int n, input int err);
        int i;
        @(posedge core_clk);
        #1;
        tok_valid = 1'b1;
        tok_pid = pid;
        tok_data_pid = dpid;
        tok_bd = bd;
        tok_ep = ep;
        hold(1'b0);
        #1;
        tok_valid = 1'b0;
        // released pid and descriptor lines are scrambled so stale values cannot pass
        tok_pid = ~tok_pid;
        tok_bd = ~tok_bd;
        for (i = 0; i < n; i++)
        begin
            rx_valid = 1'b1;
            rx_data = 8'hA0 + 8'(i);
            rx_last = (i == n - 1);
            rx_err = (i == err);
            hold(1'b1);
            #1;
        end
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule
`default_nettype wire

// [ubd_pkg.sv]
package ubd_pkg;

    // memory window seen by the core
    localparam logic [11:0] RAM_BASE     = 12'h400;
    localparam logic [11:0] RAM_LAST     = 12'h4FF;
    localparam int          RAM_BYTES    = 256;
    localparam int          RAM_AW       = 8;
    localparam int          BD_COUNT     = 64;
    localparam int          BD_BYTES     = 4;
    localparam int          EP_COUNT     = 16;

    // byte order inside one descriptor
    localparam logic [1:0]  BD_OFS_STAT  = 2'h0;
    localparam logic [1:0]  BD_OFS_CNT   = 2'h1;
    localparam logic [1:0]  BD_OFS_ADRL  = 2'h2;
    localparam logic [1:0]  BD_OFS_ADRH  = 2'h3;

    // status byte fields
    localparam int          ST_OWN       = 7;
    localparam int          ST_DTS       = 6;
    localparam int          ST_TOGGLE_CHECK_ENABLE     = 3;
    localparam int          ST_STALL     = 2;
    localparam int          ST_PID_LSB   = 2;
    localparam int          ST_BC_LSB    = 0;
    localparam int          CNT_W        = 10;

    // packet identifiers
    localparam logic [3:0]  PID_OUT      = 4'h1;
    localparam logic [3:0]  PID_IN       = 4'h9;
    localparam logic [3:0]  PID_SETUP    = 4'hD;
    localparam logic [3:0]  PID_DATA0    = 4'h3;
    localparam logic [3:0]  PID_DATA1    = 4'hB;

    // handshake codes towards the serial engine
    localparam logic [1:0]  HS_ACK       = 2'h0;
    localparam logic [1:0]  HS_NAK       = 2'h1;
    localparam logic [1:0]  HS_STALL     = 2'h2;

    // receive buffer
    localparam int          RXB_DEPTH    = 2;
    localparam int          RXB_WIDTH    = 10;

    typedef enum logic [8:0] {
        UBD_IDLE    = 9'h001,
        UBD_FETCH   = 9'h002,
        UBD_DECIDE  = 9'h004,
        UBD_RX      = 9'h008,
        UBD_TX_RD   = 9'h010,
        UBD_TX_OUT  = 9'h020,
        UBD_WR_CNT  = 9'h040,
        UBD_WR_STAT = 9'h080,
        UBD_REPLY   = 9'h100
    } ubd_state_type;

endpackage

// [ubd_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module ubd_ram #(
    parameter int RXB_DEPTH = ubd_pkg::RXB_DEPTH
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // processor data-space port
    input  wire logic                     cpu_en,
    input  wire logic                     cpu_we,
    input  wire logic [11:0]              cpu_addr,
    input  wire logic [7:0]               cpu_wdata,
    output logic      [7:0]               cpu_rdata,
    // endpoint input-enable bits from the endpoint control registers
    input  wire logic [ubd_pkg::EP_COUNT-1:0] ep_in_enable,
    // token from the serial engine
    input  wire logic                     tok_valid,
    output logic                          tok_ready,
    input  wire logic [3:0]               tok_pid,
    input  wire logic [3:0]               tok_data_pid,
    input  wire logic [5:0]               tok_bd,
    input  wire logic [3:0]               tok_ep,
    // received data bytes
    input  wire logic                     rx_valid,
    output logic                          rx_ready,
    input  wire logic [7:0]               rx_data,
    input  wire logic                     rx_last,
    input  wire logic                     rx_err,
    // transmitted data bytes
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    output logic      [7:0]               tx_data,
    output logic                          tx_last,
    // handshake and events
    output logic                          hs_valid,
    output logic      [1:0]               hs_code,
    output logic                          trn_done,
    output logic      [5:0]               trn_bd,
    output logic      [3:0]               trn_pid,
    output logic                          stall_set,
    output logic      [3:0]               stall_ep
);

    localparam int PTR_W = $clog2(RXB_DEPTH);
    localparam int W     = ubd_pkg::RXB_WIDTH;

    // no reset on the array: contents are whatever was last written
    logic [7:0]                 mem [0:ubd_pkg::RAM_BYTES-1];
    logic [7:0]                 eng_rdata;
    logic [7:0]                 eng_addr;
    logic                       eng_we;
    logic [7:0]                 eng_wdata;
    logic                       cpu_hit;

    ubd_pkg::ubd_state_type     st;
    logic [1:0]                 fetch_idx;
    logic [7:0]                 d_stat;
    logic [7:0]                 d_cnt;
    logic [7:0]                 d_adrl;
    logic [3:0]                 t_pid;
    logic [3:0]                 t_dpid;
    logic [5:0]                 t_bd;
    logic [3:0]                 t_ep;
    logic                       t_en;
    logic [10:0]                rx_cnt;
    logic                       rx_bad;
    logic [9:0]                 x_idx;
    logic [9:0]                 fin_cnt;
    logic                       hs_pend;
    logic [1:0]                 hs_sel;

    logic [W-1:0]               rxb [0:RXB_DEPTH-1];
    logic [PTR_W-1:0]           wr_ptr;
    logic [PTR_W-1:0]           rd_ptr;
    logic [PTR_W:0]             b_cnt;
    logic [PTR_W:0]             next_b_cnt;
    logic                       push;
    logic                       pop;
    logic [W-1:0]               head;

    logic [7:0]                 bd_base;
    logic [9:0]                 max_cnt;
    logic                       is_setup;
    logic                       stalled;
    logic                       tog_fail;
    logic                       usable;
    logic [10:0]                next_rx_cnt;

    function automatic logic [7:0] bd_byte(input logic [5:0] bd, input logic [1:0] ofs);
        bd_byte = {bd, ofs};
    endfunction

    assign bd_base     = bd_byte(t_bd, ubd_pkg::BD_OFS_STAT);
    assign max_cnt     = {d_stat[ubd_pkg::ST_BC_LSB+1:ubd_pkg::ST_BC_LSB], d_cnt};
    assign is_setup    = (t_pid == ubd_pkg::PID_SETUP);
    assign stalled     = d_stat[ubd_pkg::ST_STALL] && !is_setup;
    assign tog_fail    = d_stat[ubd_pkg::ST_TOGGLE_CHECK_ENABLE] &&
                         ((t_dpid == ubd_pkg::PID_DATA1) != d_stat[ubd_pkg::ST_DTS]);
    // descriptor only counts once its endpoint is enabled and engine-owned
    assign usable      = t_en && d_stat[ubd_pkg::ST_OWN];
    assign cpu_hit     = (cpu_addr[11:8] == ubd_pkg::RAM_BASE[11:8]);
    assign head        = rxb[rd_ptr];
    assign push        = rx_valid && rx_ready;
    assign pop         = (st == ubd_pkg::UBD_RX) && (b_cnt != '0);
    assign next_rx_cnt = rx_cnt + 11'h001;
    assign next_b_cnt  = b_cnt + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

    // engine port address and write data
    always_comb
    begin
        eng_addr  = bd_base;
        eng_we    = 1'b0;
        eng_wdata = 8'h00;
        case (st)
            ubd_pkg::UBD_FETCH:
                eng_addr = bd_byte(t_bd, fetch_idx);
            ubd_pkg::UBD_RX:
            begin
                // address high byte is not checked, buffers live in the low byte
                eng_addr  = d_adrl + rx_cnt[7:0];
                eng_wdata = head[7:0];
                // bad toggle, stall or overflow: the byte never reaches memory
                eng_we    = pop && usable && !stalled && !tog_fail && !head[9] &&
                            (rx_cnt < {1'b0, max_cnt});
            end
            ubd_pkg::UBD_TX_RD:
                eng_addr = d_adrl + x_idx[7:0];
            ubd_pkg::UBD_WR_CNT:
            begin
                eng_addr  = bd_byte(t_bd, ubd_pkg::BD_OFS_CNT);
                eng_we    = 1'b1;
                eng_wdata = fin_cnt[7:0];
            end
            ubd_pkg::UBD_WR_STAT:
            begin
                eng_we    = 1'b1;
                // ownership back to the core, pid and upper count recorded
                eng_wdata = {1'b0, 1'b0, t_pid, fin_cnt[9:8]};
            end
            default:
                eng_addr = bd_base;
        endcase
    end

    // dual-port array; the engine write is last so it wins a same-address clash
    always_ff @(posedge core_clk)
    begin
        if (cpu_en && cpu_we && cpu_hit)
            mem[cpu_addr[7:0]] <= cpu_wdata;
        if (eng_we)
            mem[eng_addr] <= eng_wdata;
        eng_rdata <= mem[eng_addr];
    end

    // processor read, never held off by ownership
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            cpu_rdata <= 8'h00;
        else if (cpu_en && !cpu_we)
            cpu_rdata <= cpu_hit ? mem[cpu_addr[7:0]] : 8'h00;
    end

    // receive buffer: lets the engine keep streaming while a byte is written
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            b_cnt    <= '0;
            rx_ready <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                rxb[wr_ptr] <= {rx_err, rx_last, rx_data};
                wr_ptr      <= (wr_ptr == PTR_W'(RXB_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == PTR_W'(RXB_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            b_cnt    <= next_b_cnt;
            rx_ready <= (next_b_cnt < (PTR_W+1)'(RXB_DEPTH));
        end
    end

    // transaction sequencer
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st        <= ubd_pkg::UBD_IDLE;
            tok_ready <= 1'b1;
            fetch_idx <= 2'h0;
            d_stat    <= 8'h00;
            d_cnt     <= 8'h00;
            d_adrl    <= 8'h00;
            t_pid     <= 4'h0;
            t_dpid    <= 4'h0;
            t_bd      <= 6'h00;
            t_ep      <= 4'h0;
            t_en      <= 1'b0;
            rx_cnt    <= 11'h000;
            rx_bad    <= 1'b0;
            x_idx     <= 10'h000;
            fin_cnt   <= 10'h000;
            hs_pend   <= 1'b0;
            hs_sel    <= 2'h0;
            hs_valid  <= 1'b0;
            hs_code   <= 2'h0;
            trn_done  <= 1'b0;
            trn_bd    <= 6'h00;
            trn_pid   <= 4'h0;
            stall_set <= 1'b0;
            stall_ep  <= 4'h0;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
            tx_last   <= 1'b0;
        end
        else
        begin
            hs_valid  <= 1'b0;
            trn_done  <= 1'b0;
            stall_set <= 1'b0;
            case (st)
                ubd_pkg::UBD_IDLE:
                    if (tok_valid && tok_ready)
                    begin
                        tok_ready <= 1'b0;
                        t_pid     <= tok_pid;
                        t_dpid    <= tok_data_pid;
                        t_bd      <= tok_bd;
                        t_ep      <= tok_ep;
                        t_en      <= ep_in_enable[tok_ep];
                        fetch_idx <= ubd_pkg::BD_OFS_STAT;
                        rx_cnt    <= 11'h000;
                        rx_bad    <= 1'b0;
                        x_idx     <= 10'h000;
                        hs_pend   <= 1'b0;
                        st        <= ubd_pkg::UBD_FETCH;
                    end
                ubd_pkg::UBD_FETCH:
                begin
                    // one read per cycle, each byte lands a cycle after its address
                    fetch_idx <= fetch_idx + 2'h1;
                    if (fetch_idx == ubd_pkg::BD_OFS_CNT)
                        d_stat <= eng_rdata;
                    if (fetch_idx == ubd_pkg::BD_OFS_ADRL)
                        d_cnt <= eng_rdata;
                    if (fetch_idx == ubd_pkg::BD_OFS_ADRH)
                    begin
                        d_adrl <= eng_rdata;
                        st     <= (t_pid == ubd_pkg::PID_IN) ? ubd_pkg::UBD_DECIDE
                                                             : ubd_pkg::UBD_RX;
                    end
                end
                ubd_pkg::UBD_DECIDE:
                begin
                    hs_pend <= 1'b1;
                    st      <= ubd_pkg::UBD_REPLY;
                    if (t_en && d_stat[ubd_pkg::ST_STALL])
                    begin
                        hs_sel    <= ubd_pkg::HS_STALL;
                        stall_set <= 1'b1;
                        stall_ep  <= t_ep;
                    end
                    else if (!usable)
                        hs_sel <= ubd_pkg::HS_NAK;
                    else
                    begin
                        hs_pend <= 1'b0;
                        fin_cnt <= max_cnt;
                        st      <= (max_cnt == 10'h000) ? ubd_pkg::UBD_WR_CNT
                                                        : ubd_pkg::UBD_TX_RD;
                    end
                end
                ubd_pkg::UBD_RX:
                    if (pop)
                    begin
                        rx_cnt <= next_rx_cnt;
                        rx_bad <= rx_bad || head[9];
                        if (head[8])
                        begin
                            hs_pend <= 1'b1;
                            st      <= ubd_pkg::UBD_REPLY;
                            fin_cnt <= next_rx_cnt[9:0];
                            if (rx_bad || head[9])
                                hs_sel <= ubd_pkg::HS_NAK;
                            else if (next_rx_cnt > {1'b0, max_cnt})
                                hs_sel <= ubd_pkg::HS_NAK;
                            else if (t_en && stalled)
                            begin
                                hs_sel    <= ubd_pkg::HS_STALL;
                                stall_set <= 1'b1;
                                stall_ep  <= t_ep;
                            end
                            else if (!usable)
                                hs_sel <= ubd_pkg::HS_NAK;
                            else if (tog_fail)
                                hs_sel <= ubd_pkg::HS_ACK;
                            else
                            begin
                                hs_sel <= ubd_pkg::HS_ACK;
                                st     <= ubd_pkg::UBD_WR_CNT;
                            end
                        end
                    end
                ubd_pkg::UBD_TX_RD:
                    st <= ubd_pkg::UBD_TX_OUT;
                ubd_pkg::UBD_TX_OUT:
                    if (!tx_valid)
                    begin
                        tx_valid <= 1'b1;
                        tx_data  <= eng_rdata;
                        tx_last  <= (x_idx == max_cnt - 10'h001);
                    end
                    else if (tx_ready)
                    begin
                        tx_valid <= 1'b0;
                        tx_last  <= 1'b0;
                        x_idx    <= x_idx + 10'h001;
                        st       <= tx_last ? ubd_pkg::UBD_WR_CNT : ubd_pkg::UBD_TX_RD;
                    end
                ubd_pkg::UBD_WR_CNT:
                    st <= ubd_pkg::UBD_WR_STAT;
                ubd_pkg::UBD_WR_STAT:
                begin
                    trn_done <= 1'b1;
                    trn_bd   <= t_bd;
                    trn_pid  <= t_pid;
                    st       <= ubd_pkg::UBD_REPLY;
                end
                ubd_pkg::UBD_REPLY:
                begin
                    hs_valid  <= hs_pend;
                    hs_code   <= hs_sel;
                    tok_ready <= 1'b1;
                    st        <= ubd_pkg::UBD_IDLE;
                end
                default:
                begin
                    tok_ready <= 1'b1;
                    st        <= ubd_pkg::UBD_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [ubd_ram_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ubd_ram_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // processor port
    input wire logic        cpu_en,
    input wire logic        cpu_we,
    input wire logic [11:0] cpu_addr,
    input wire logic [7:0]  cpu_rdata,
    // engine side
    input wire logic        tok_valid,
    input wire logic        tok_ready,
    input wire logic [3:0]  tok_pid,
    input wire logic [5:0]  tok_bd,
    input wire logic [3:0]  tok_ep,
    input wire logic        hs_valid,
    input wire logic [1:0]  hs_code,
    input wire logic        trn_done,
    input wire logic [5:0]  trn_bd,
    input wire logic [3:0]  trn_pid,
    input wire logic        stall_set,
    input wire logic [3:0]  stall_ep
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // token fields kept so later events can be tied to their cause
    logic [3:0] pid_q;
    logic [5:0] bd_q;
    logic [3:0] ep_q;

    always_ff @(posedge core_clk)
    begin
        if (tok_valid && tok_ready)
        begin
            pid_q <= tok_pid;
            bd_q  <= tok_bd;
            ep_q  <= tok_ep;
        end
    end

    hs_pulse_a: assert property (hs_valid |=> !hs_valid)
        else $error("handshake pulse longer than one cycle");
    done_pulse_a: assert property (trn_done |=> !trn_done)
        else $error("done pulse longer than one cycle");
    done_ack_a: assert property (
        trn_done && pid_q != ubd_pkg::PID_IN |=> hs_valid && hs_code == ubd_pkg::HS_ACK)
        else $error("completed packet not answered with ACK");
    done_tags_a: assert property (trn_done |-> trn_bd == bd_q && trn_pid == pid_q)
        else $error("completion names wrong descriptor or token");
    stall_ep_a: assert property (stall_set |-> stall_ep == ep_q)
        else $error("stall event names wrong endpoint");
    stall_reply_a: assert property (
        stall_set && pid_q != ubd_pkg::PID_IN |-> ##[0:3] (hs_valid && hs_code == ubd_pkg::HS_STALL))
        else $error("stall event without STALL handshake");
    fetch_quiet_a: assert property (
        tok_valid && tok_ready |=> (!hs_valid && !trn_done) [*4])
        else $error("answer before the four descriptor bytes were fetched");
    outside_zero_a: assert property (
        cpu_en && !cpu_we && (cpu_addr < ubd_pkg::RAM_BASE || cpu_addr > ubd_pkg::RAM_LAST)
        |=> cpu_rdata == 8'h00)
        else $error("read outside the window not zero");

    cover property (trn_done && pid_q == ubd_pkg::PID_IN);
    cover property (stall_set);
    cover property (hs_valid && hs_code == ubd_pkg::HS_NAK);
endmodule

bind ubd_ram ubd_ram_props chk_u (.*);
`default_nettype wire
